// ===== inc/rsg_pkg.sv
package rsg_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned READY_HOLD_MS   = 40;
  localparam int unsigned IRQ_LOW_MS      = 5;
  localparam int unsigned READY_HOLD_CYC  = (CLK_HZ / 1000) * READY_HOLD_MS;
  localparam int unsigned IRQ_LOW_CYC     = (CLK_HZ / 1000) * IRQ_LOW_MS;
  localparam int unsigned CNT_W           = 19;

  // ****************************************
  // Pin functions and encodings
  // ****************************************
  localparam logic [1:0] PIN_FN_HIZ       = 2'h0;
  localparam logic [1:0] PIN_FN_IRQ       = 2'h1;
  localparam logic [1:0] PIN_FN_LOW       = 2'h2;
  localparam logic [1:0] PIN_FN_HIGH      = 2'h3;
  localparam logic [1:0] ERR_NONE         = 2'h0;
  localparam logic [1:0] ERR_LOW          = 2'h1;
  localparam logic [1:0] ERR_MID          = 2'h2;
  localparam logic [1:0] ERR_BAD          = 2'h3;
  localparam logic [3:0] ERR_LOW_MAX      = 4'h2;
  localparam logic [3:0] ERR_MID_MAX      = 4'h5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic       RST_WIRE3        = 1'b0;

endpackage

// ===== hw/rsg_hold_timer.sv
`timescale 1ns/1ps
module rsg_hold_timer #(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic clear,
  output logic      active
);

  // ****************************************
  // Retriggerable down counter
  // ****************************************
  typedef struct packed {
    logic [rsg_pkg::CNT_W-1:0] cnt;
  } rsg_tmr_state_t;

  rsg_tmr_state_t st_q;
  rsg_tmr_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (start) begin
      st_d.cnt = rsg_pkg::CNT_W'(CYCLES);
    end else if (clear) begin
      st_d.cnt = '0;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - rsg_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign active = (st_q.cnt != '0);

endmodule

// ===== hw/rsg_status_pins.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Pins one and three select bus mode
// [RULE2] Pins act as GPIO, IRQ, stereo
// [RULE3] Host waits powerup before IRQ use
// [RULE4] GPIO works regardless of supplies, enables
// [RULE5] Decoder syncs, detects and corrects blocks
// [RULE6] Decoding runs only when enabled
// [RULE7] Mode bit low selects standard mode
// [RULE8] Standard valid group: ready 40 ms
// [RULE9] Standard valid group: pin low 5 ms
// [RULE10] Invalid group: no ready, no pulse (code: standard mode only; verbose takes any synced group)
// [RULE11] Standard mode: sync, error levels zero
// [RULE12] Mode bit high selects verbose mode
// [RULE13] Verbose: sync flag follows synchronization
// [RULE14] Verbose synced group: ready 40 ms
// [RULE15] Verbose synced group: pin low 5 ms
// [RULE16] Error levels: 00,01,10,11 by count
// [RULE17] Host discards six-plus error blocks
// [RULE18] Seek done: pin low 5 ms
// [RULE19] Shared pin pulses for either event
module rsg_status_pins (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       decoder_enable,
  input  wire logic       decoder_verbose_select,
  input  wire logic       group_interrupt_enable,
  input  wire logic       seek_done_interrupt_enable,
  input  wire logic [1:0] pin_one_function_field,
  input  wire logic [1:0] pin_two_function_field,
  input  wire logic [1:0] pin_three_function_field,
  input  wire logic       stereo_indicator,
  input  wire logic       seek_done_flag,
  input  wire logic       group_done,
  input  wire logic       group_valid,
  input  wire logic       stream_synced,
  input  wire logic [3:0] block_a_bit_errors,
  input  wire logic [3:0] block_b_bit_errors,
  input  wire logic [3:0] block_c_bit_errors,
  input  wire logic [3:0] block_d_bit_errors,
  input  wire logic       general_pin_one_in,
  input  wire logic       general_pin_two_in,
  input  wire logic       general_pin_three_in,
  output logic            general_pin_one_out,
  output logic            general_pin_one_oe,
  output logic            general_pin_two_out,
  output logic            general_pin_two_oe,
  output logic            general_pin_three_out,
  output logic            general_pin_three_oe,
  output logic [2:0]      general_pin_level,
  output logic            bus_three_wire,
  output logic            group_ready_flag,
  output logic            decoder_sync_flag,
  output logic [1:0]      block_a_error_level,
  output logic [1:0]      block_b_error_level,
  output logic [1:0]      block_c_error_level,
  output logic [1:0]      block_d_error_level
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic       in_reset;
    logic       wire3;
    logic       seek_prev;
    logic       sync;
    logic [7:0] blk_err;
  } rsg_state_t;

  rsg_state_t st_q;
  rsg_state_t st_d;

  logic       take_group;
  logic       seek_rise;
  logic       ready_act;
  logic       irq_act;
  logic       irq_start;
  logic [1:0] lvl [4];
  logic [3:0] errs [4];

  assign errs[0] = block_a_bit_errors;
  assign errs[1] = block_b_bit_errors;
  assign errs[2] = block_c_bit_errors;
  assign errs[3] = block_d_bit_errors;

  // ****************************************
  // Error level encoding
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lvl
      always_comb begin
        if (errs[gi] == 4'h0) begin
          lvl[gi] = rsg_pkg::ERR_NONE; // [RULE16]
        end else if (errs[gi] <= rsg_pkg::ERR_LOW_MAX) begin
          lvl[gi] = rsg_pkg::ERR_LOW; // [RULE16]
        end else if (errs[gi] <= rsg_pkg::ERR_MID_MAX) begin
          lvl[gi] = rsg_pkg::ERR_MID; // [RULE16]
        end else begin
          lvl[gi] = rsg_pkg::ERR_BAD; // [RULE16]
        end
      end
    end
  endgenerate

  // ****************************************
  // Group acceptance
  // ****************************************
  always_comb begin
    take_group = 1'b0;
    if (decoder_enable && group_done) begin // [RULE5] [RULE6]
      if (decoder_verbose_select) begin
        take_group = stream_synced; // [RULE12] [RULE14]
      end else begin
        take_group = group_valid; // [RULE7] [RULE8] [RULE10]
      end
    end
  end

  assign seek_rise = seek_done_flag && !st_q.seek_prev;
  assign irq_start = (take_group && group_interrupt_enable) // [RULE9] [RULE15]
                   || (seek_rise && seek_done_interrupt_enable); // [RULE18] [RULE19]

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d           = st_q;
    st_d.pin_s1    = {general_pin_three_in, general_pin_two_in, general_pin_one_in};
    st_d.pin_s2    = st_q.pin_s1;
    st_d.in_reset  = 1'b0;
    st_d.seek_prev = seek_done_flag;
    if (st_q.in_reset) begin
      st_d.wire3 = st_q.pin_s2[0] && !st_q.pin_s2[2]; // [RULE1]
    end
    st_d.sync = decoder_enable && decoder_verbose_select && stream_synced; // [RULE13] [RULE11]
    if (take_group && decoder_verbose_select) begin
      st_d.blk_err = {lvl[3], lvl[2], lvl[1], lvl[0]};
    end
    if (!decoder_enable || !decoder_verbose_select) begin
      st_d.blk_err = '0; // [RULE11]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.pin_s1   <= st_d.pin_s1;
      st_q.pin_s2   <= st_d.pin_s2; // [RULE1]
      st_q.in_reset <= 1'b1;
      st_q.wire3    <= rsg_pkg::RST_WIRE3;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Hold timers
  // ****************************************
  rsg_hold_timer #(
    .CYCLES (rsg_pkg::READY_HOLD_CYC)
  ) u_ready (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (take_group), // [RULE8] [RULE14]
    .clear    (!decoder_enable),
    .active   (ready_act)
  );

  rsg_hold_timer #(
    .CYCLES (rsg_pkg::IRQ_LOW_CYC)
  ) u_irq (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (irq_start),
    .clear    (1'b0),
    .active   (irq_act)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign group_ready_flag    = ready_act;
  assign decoder_sync_flag   = st_q.sync;
  assign block_a_error_level = st_q.blk_err[1:0];
  assign block_b_error_level = st_q.blk_err[3:2];
  assign block_c_error_level = st_q.blk_err[5:4];
  assign block_d_error_level = st_q.blk_err[7:6];
  assign general_pin_level   = st_q.pin_s2; // [RULE4]
  assign bus_three_wire      = st_q.wire3;

  // Pin drivers, independent of supplies and enables
  always_comb begin
    general_pin_one_oe    = pin_one_function_field[1]; // [RULE2] [RULE4]
    general_pin_one_out   = pin_one_function_field[0];
    general_pin_three_oe  = (pin_three_function_field != rsg_pkg::PIN_FN_HIZ); // [RULE2]
    general_pin_three_out = (pin_three_function_field == rsg_pkg::PIN_FN_IRQ)
                          ? stereo_indicator : pin_three_function_field[0];
    unique case (pin_two_function_field)
      rsg_pkg::PIN_FN_HIZ: begin
        general_pin_two_oe  = 1'b0;
        general_pin_two_out = 1'b0;
      end
      rsg_pkg::PIN_FN_IRQ: begin
        general_pin_two_oe  = 1'b1;
        general_pin_two_out = !irq_act; // [RULE9] [RULE15] [RULE18]
      end
      rsg_pkg::PIN_FN_LOW: begin
        general_pin_two_oe  = 1'b1;
        general_pin_two_out = 1'b0;
      end
      rsg_pkg::PIN_FN_HIGH: begin
        general_pin_two_oe  = 1'b1;
        general_pin_two_out = 1'b1;
      end
    endcase
  end

endmodule

// ===== sim/rsg_status_pins_chk.sv
`timescale 1ns/1ps
module rsg_status_pins_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       decoder_enable,
  input wire logic       decoder_verbose_select,
  input wire logic       group_interrupt_enable,
  input wire logic [1:0] pin_two_function_field,
  input wire logic       group_done,
  input wire logic       group_valid,
  input wire logic       stream_synced,
  input wire logic       general_pin_two_out,
  input wire logic       group_ready_flag,
  input wire logic       decoder_sync_flag
);
  // ****
  // Checks
  // ****
  wire ev = group_done && decoder_enable;
  wire vb = decoder_verbose_select;
  wire ok = vb ? stream_synced : group_valid;
  wire ie = group_interrupt_enable && pin_two_function_field == rsg_pkg::PIN_FN_IRQ;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rdy; ev && !vb && group_valid |=> group_ready_flag; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_irq; ev && ok && ie |=> !general_pin_two_out; endproperty
  a_irq: assert property (p_irq) else $error("no pulse");
  property p_bad; ev && !vb && !group_valid && !group_ready_flag |=> !group_ready_flag; endproperty
  a_bad: assert property (p_bad) else $error("bad group");
  property p_zero; !vb |=> !decoder_sync_flag; endproperty
  a_zero: assert property (p_zero) else $error("sync in standard");
  property p_son; decoder_enable && vb && stream_synced |=> decoder_sync_flag; endproperty
  a_son: assert property (p_son) else $error("sync low");
  property p_soff; !stream_synced |=> !decoder_sync_flag; endproperty
  a_soff: assert property (p_soff) else $error("sync high");
  property p_vrdy; ev && vb && stream_synced |=> group_ready_flag; endproperty
  a_vrdy: assert property (p_vrdy) else $error("no verbose ready");
  property p_off; !decoder_enable |=> !group_ready_flag; endproperty
  a_off: assert property (p_off) else $error("ready while off");
  c_irq: cover property (ev && ok && ie ##1 !general_pin_two_out);
  c_bad: cover property (ev && !vb && !group_valid);
  c_vrb: cover property (ev && vb && stream_synced);
endmodule

// ===== sim/rsg_host_model.sv
`timescale 1ns/1ps
module rsg_host_model (
  input  wire logic       core_clk,
  input  wire logic [2:0] drive,
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  output logic      [2:0] pin_in,
  output int              irq_count
);
  logic prev_q;
  // Driven pin wins, else host level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
  initial irq_count = 0;
  // Counts falls of the shared request pin
  always @(posedge core_clk) begin
    if (prev_q && !pin_in[1]) begin
      irq_count <= irq_count + 1;
    end
    prev_q <= pin_in[1];
  end
endmodule

// ===== sim/rsg_status_pins_test.sv
`timescale 1ns/1ps
module rsg_status_pins_test;
  logic        core_clk, rst_n, decoder_enable, decoder_verbose_select, stereo_indicator;
  logic        group_interrupt_enable, seek_done_interrupt_enable, seek_done_flag;
  logic        group_done, group_valid, stream_synced, bus_three_wire, group_ready_flag;
  logic        decoder_sync_flag;
  logic [1:0]  f;
  logic [2:0]  drv, po, oe, pi, general_pin_level;
  logic [7:0]  lv;
  logic [15:0] errs;
  int          bad_count, n_compared, k, irqs;
  wire  [10:0] st = {group_ready_flag, po[1], decoder_sync_flag, lv};
  localparam logic [8:0] ROWS [6] = '{9'h000, 9'h03f, 9'h138, 9'h187, 9'h0bb, 9'h0ff};
  always #50 core_clk = ~core_clk;
  rsg_host_model u_host (.core_clk, .drive(drv), .pin_out(po), .pin_oe(oe), .pin_in(pi),
    .irq_count(irqs));
  rsg_status_pins u_dut (.*, .pin_one_function_field(f), .pin_two_function_field(f),
    .pin_three_function_field(f), .block_a_bit_errors(errs[15:12]),
    .block_b_bit_errors(errs[11:8]), .block_c_bit_errors(errs[7:4]),
    .block_d_bit_errors(errs[3:0]), .general_pin_one_in(pi[0]), .general_pin_two_in(pi[1]),
    .general_pin_three_in(pi[2]), .general_pin_one_out(po[0]), .general_pin_one_oe(oe[0]),
    .general_pin_two_out(po[1]), .general_pin_two_oe(oe[1]), .general_pin_three_out(po[2]),
    .general_pin_three_oe(oe[2]), .block_a_error_level(lv[7:6]),
    .block_b_error_level(lv[5:4]), .block_c_error_level(lv[3:2]),
    .block_d_error_level(lv[1:0]));
  task automatic chk(input logic [11:0] seen, input logic [11:0] want);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic grp(input logic v, input logic [15:0] e);
    @(posedge core_clk);
    group_done <= 1'b1;
    group_valid <= v;
    errs <= e;
    @(posedge core_clk);
    group_done <= 1'b0;
    #1;
  endtask
  task automatic rst(input logic [2:0] d, input logic exp);
    @(posedge core_clk);
    rst_n <= 1'b0;
    drv <= d;
    f <= 2'h0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({bus_three_wire, group_ready_flag}, {exp, 1'b0});
  endtask
  initial begin
    #6_000_000;
    bad_count++;
    summarize();
  end
  initial begin
    {core_clk, rst_n, decoder_enable, decoder_verbose_select, stereo_indicator} = '0;
    {group_interrupt_enable, seek_done_interrupt_enable, seek_done_flag} = '0;
    {group_done, group_valid, stream_synced, f, drv, errs} = '0;
    rst(3'h1, 1'b1);
    foreach (ROWS[i]) begin
      @(posedge core_clk);
      {f, stereo_indicator, drv} <= ROWS[i][8:3];
      repeat (4) @(posedge core_clk);
      #1;
      chk(general_pin_level, ROWS[i][2:0]);
    end
    $display("T1 done");
    @(posedge core_clk);
    {f, group_interrupt_enable, stream_synced} <= 4'h7;
    grp(1'b1, 16'h0000);
    chk(group_ready_flag, 1'b0);
    @(posedge core_clk);
    decoder_enable <= 1'b1;
    grp(1'b0, 16'h0000);
    chk(st[10:9], 2'h1);
    grp(1'b1, 16'h2356);
    chk(st, 12'h400);
    repeat (49999) @(posedge core_clk);
    #1;
    chk(st, 12'h400);
    @(posedge core_clk);
    #1;
    chk(st, 12'h600);
    $display("T2 done");
    rst(3'h5, 1'b0);
    @(posedge core_clk);
    {f, decoder_verbose_select, stream_synced} <= 4'h6;
    grp(1'b1, 16'h0000);
    chk(st, 12'h200);
    @(posedge core_clk);
    stream_synced <= 1'b1;
    grp(1'b0, 16'h0256);
    chk(st, 12'h51b);
    grp(1'b0, 16'h13f1);
    chk(st, 12'h56d);
    @(posedge core_clk);
    stream_synced <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(decoder_sync_flag, 1'b0);
    $display("T3 done");
    rst(3'h1, 1'b1);
    @(posedge core_clk);
    {f, decoder_verbose_select, seek_done_interrupt_enable} <= 4'h5;
    k = irqs;
    @(posedge core_clk);
    seek_done_flag <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk({st[10:9], 4'(irqs - k)}, 6'h01);
    grp(1'b1, 16'h0000);
    chk(st[10:9], 2'h2);
    @(posedge core_clk);
    decoder_enable <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(group_ready_flag, 1'b0);
    $display("T4 done");
    summarize();
  end
endmodule
bind rsg_status_pins rsg_status_pins_chk u_chk (.*);
